//--- rtl/uls_pkg.sv
// constants, field positions and types shared by the line status block
// assumes one 100 MHz clock and an 8-bit register port with 3 address bits
package uls_pkg;

  // register port shape
  localparam int unsigned ADDR_W   = 3;
  localparam int unsigned DATA_W   = 8;

  // queue shape: 16 entries, pointer and fill count widths
  localparam int unsigned DEPTH    = 16;
  localparam int unsigned PTR_W    = 4;
  localparam int unsigned CNT_W    = 5;
  localparam logic [4:0]  CAP_FIFO = 5'h10;
  localparam logic [4:0]  CAP_ONE  = 5'h01;

  // receive entry: data in [7:0], tags above it
  localparam int unsigned RX_W     = 11;
  localparam int unsigned TAG_PE   = 8;
  localparam int unsigned TAG_FE   = 9;
  localparam int unsigned TAG_BI   = 10;
  localparam logic [10:0] BRK_ENTRY = 11'h400;

  // register offsets
  localparam logic [2:0] OFS_DATA  = 3'h0;
  localparam logic [2:0] OFS_LSW   = 3'h1;
  localparam logic [2:0] OFS_CTRL  = 3'h2;
  localparam logic [2:0] OFS_EVT   = 3'h3;
  localparam logic [2:0] OFS_MASK  = 3'h4;

  // line_status_word bit positions
  localparam int unsigned LSW_DR   = 0;
  localparam int unsigned LSW_OE   = 1;
  localparam int unsigned LSW_PE   = 2;
  localparam int unsigned LSW_FE   = 3;
  localparam int unsigned LSW_BI   = 4;
  localparam int unsigned LSW_THRE = 5;
  localparam int unsigned LSW_TEMT = 6;
  localparam int unsigned LSW_FERR = 7;

  // control register fields and reset values
  localparam int unsigned CTRL_FIFO_EN  = 0;
  localparam int unsigned CTRL_FRAME_LO = 4;
  localparam int unsigned CTRL_FRAME_HI = 7;
  localparam logic [7:0]  CTRL_RST      = 8'hA0;
  localparam logic [4:0]  MASK_RST      = 5'h00;

  // event status bits
  localparam int unsigned EVT_W    = 5;
  localparam int unsigned EVT_RX   = 0;
  localparam int unsigned EVT_OE   = 1;
  localparam int unsigned EVT_ERR  = 2;
  localparam int unsigned EVT_BI   = 3;
  localparam int unsigned EVT_THRE = 4;

  // break detector states
  typedef enum logic [2:0] {
    BRK_IDLE  = 3'b001,
    BRK_COUNT = 3'b010,
    BRK_HELD  = 3'b100
  } uls_brk_state_t;

endpackage

//--- rtl/uls_mem.sv
// small two-port memory with a registered read port
// assumes one clock; a write to the address being read is passed through
module uls_mem #(
  parameter int unsigned W  = 8,
  parameter int unsigned D  = 16,
  parameter int unsigned AW = 4
) (
  // clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          reset_n_in,
  // write port
  input  wire logic          wr_en_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [W-1:0]  wr_data_in,
  // read port
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [W-1:0]  rd_data_out
);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [W-1:0]        q;
  } uls_mem_state_t;

  uls_mem_state_t st_reg;
  uls_mem_state_t st_next;

  // store and read, with write-through on address match
  always_comb
  begin
    st_next = st_reg;
    if (wr_en_in)
    begin
      st_next.mem[wr_addr_in] = wr_data_in;
    end
    st_next.q = st_next.mem[rd_addr_in];
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign rd_data_out = st_reg.q;

endmodule // uls_mem

//--- rtl/uls_line_status.sv
// line status flags of a serial transceiver, receive and transmit queues
// assumes a receiver giving finished characters and bit-time ticks, and a
// transmit shifter that takes characters by handshake; one clock domain
//
// What this block does
// RULE_01: queue mode: bit 7 set while receive queue holds a parity, framing or break character. Here a status read clears it even while one remains.
// RULE_02: reading line_status_word clears bit 7.
// RULE_03: single-buffer mode: bit 6 high when holding and shift registers both empty.
// RULE_04: queue mode: bit 6 high when transmit queue and shifter both empty.
// RULE_05: single-buffer mode: bit 5 sets when the shifter takes the held character.
// RULE_06: single-buffer mode: bit 5 clears with the processor write of a character.
// RULE_07: bit 5 raises an interrupt when its enable is on.
// RULE_08: queue mode: bit 5 set when queue empties, cleared by one written byte.
// RULE_09: bit 4 reports break after serial input low a whole frame.
// RULE_10: a continuing break loads only one break character.
// RULE_11: error and break flags read zero when nothing was detected.
// RULE_12: bit 3 is framing error of the character at queue top.
// RULE_13: bit 2 is parity error of the character at queue top.
// RULE_14: bit 1 flags overrun when full; queue contents are kept.
// RULE_15: bit 0 high while received data is held.
// RULE_16: a break is stored as an all-zero character tagged as break.
//
// The strobed register port and the placing of the registers are this design's own decisions.
module uls_line_status (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // register port
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_strobe_in,
  input  wire logic       rd_strobe_in,
  output logic      [7:0] rd_data_out,
  // receiver side
  input  wire logic       rx_line_in,
  input  wire logic       rx_bit_tick_in,
  input  wire logic       rx_char_valid_in,
  input  wire logic [7:0] rx_char_data_in,
  input  wire logic       rx_parity_err_in,
  input  wire logic       rx_framing_err_in,
  // transmit shifter side
  output logic            tx_char_valid_out,
  output logic      [7:0] tx_char_data_out,
  input  wire logic       tx_char_take_in,
  input  wire logic       tx_shift_busy_in,
  // interrupt
  output logic            irq_out
);

  typedef struct packed {
    logic [7:0]                 ctrl;
    logic [4:0]                 mask;
    logic [4:0]                 evt;
    logic [7:0]                 rd_data;
    logic [3:0]                 rx_wp;
    logic [3:0]                 rx_rp;
    logic [4:0]                 rx_cnt;
    logic [3:0]                 tx_wp;
    logic [3:0]                 tx_rp;
    logic [4:0]                 tx_cnt;
    logic                       oe;
    logic                       ferr;
    logic [4:0]                 err_cnt;
    uls_pkg::uls_brk_state_t    brk_state;
    logic [3:0]                 brk_cnt;
  } uls_state_t;

  uls_state_t  st_reg;
  uls_state_t  st_next;

  // address match, used by every strobe decode
  function automatic logic bus_hit(input logic [2:0] a, input logic [2:0] ofs);
    bus_hit = (a == ofs);
  endfunction

  // any error tag on a receive entry
  function automatic logic is_err(input logic [10:0] e);
    is_err = e[uls_pkg::TAG_PE] | e[uls_pkg::TAG_FE] | e[uls_pkg::TAG_BI];
  endfunction

  logic        fifo_en;
  logic [3:0]  frame_bits;
  logic [4:0]  cap;
  logic        rx_has;
  logic        rx_full;
  logic        tx_empty;
  logic        data_wr;
  logic        ctrl_wr;
  logic        mask_wr;
  logic        lsw_rd;
  logic        data_rd;
  logic        evt_rd;
  logic        flush;
  logic [3:0]  brk_cnt_inc;
  logic        brk_push;
  logic        char_in;
  logic        rx_new;
  logic        rx_push;
  logic        overrun;
  logic [10:0] rx_entry;
  logic [10:0] rx_q;
  logic        push_err;
  logic        pop_err;
  logic        tx_pop;
  logic        thre_rise;
  logic [7:0]  lsw;
  logic [4:0]  evt_set;
  logic [4:0]  err_cnt_nx;

  // mode and capacity: one entry deep unless queue mode is on
  assign fifo_en    = st_reg.ctrl[uls_pkg::CTRL_FIFO_EN];
  assign frame_bits = st_reg.ctrl[uls_pkg::CTRL_FRAME_HI:uls_pkg::CTRL_FRAME_LO];
  assign cap        = fifo_en ? uls_pkg::CAP_FIFO : uls_pkg::CAP_ONE;
  assign rx_has     = (st_reg.rx_cnt != 5'h00);
  assign rx_full    = (st_reg.rx_cnt >= cap);
  assign tx_empty   = (st_reg.tx_cnt == 5'h00);

  // register port decode; writes to a full transmit queue are dropped
  assign data_wr = wr_strobe_in & bus_hit(addr_in, uls_pkg::OFS_DATA) & (st_reg.tx_cnt < cap);
  assign ctrl_wr = wr_strobe_in & bus_hit(addr_in, uls_pkg::OFS_CTRL);
  assign mask_wr = wr_strobe_in & bus_hit(addr_in, uls_pkg::OFS_MASK);
  assign lsw_rd  = rd_strobe_in & bus_hit(addr_in, uls_pkg::OFS_LSW);
  assign data_rd = rd_strobe_in & bus_hit(addr_in, uls_pkg::OFS_DATA) & rx_has;
  assign evt_rd  = rd_strobe_in & bus_hit(addr_in, uls_pkg::OFS_EVT);
  assign flush   = ctrl_wr & (wr_data_in[uls_pkg::CTRL_FIFO_EN] != fifo_en);

  // break: low for frame_bits bit ticks, one entry per break
  assign brk_cnt_inc = (st_reg.brk_state == uls_pkg::BRK_IDLE) ? 4'h1 : st_reg.brk_cnt + 4'h1;
  assign brk_push    = ~rx_line_in & rx_bit_tick_in & (brk_cnt_inc == frame_bits)
                       & (st_reg.brk_state != uls_pkg::BRK_HELD);             // [RULE_09] [RULE_10]

  // receive queue entry and admission
  assign char_in  = rx_char_valid_in & (st_reg.brk_state != uls_pkg::BRK_HELD) & ~brk_push;
  assign rx_new   = brk_push | char_in;
  assign overrun  = rx_new & rx_full & ~flush;                                // [RULE_14]
  assign rx_push  = rx_new & ~rx_full & ~flush;                               // [RULE_14]
  assign rx_entry = brk_push ? uls_pkg::BRK_ENTRY                             // [RULE_16]
                             : {1'b0, rx_framing_err_in, rx_parity_err_in, rx_char_data_in};
  assign push_err = rx_push & is_err(rx_entry);
  assign pop_err  = data_rd & is_err(rx_q);

  // transmit queue drain toward the shifter
  assign tx_pop    = tx_char_take_in & ~tx_empty;
  assign thre_rise = tx_pop & (st_reg.tx_cnt == 5'h01) & ~data_wr & ~flush;   // [RULE_05] [RULE_08]
  assign tx_char_valid_out = ~tx_empty;

  // line_status_word built from live state
  always_comb
  begin
    lsw = 8'h00;
    lsw[uls_pkg::LSW_DR]   = rx_has;                                          // [RULE_15]
    lsw[uls_pkg::LSW_OE]   = st_reg.oe;                                       // [RULE_14]
    lsw[uls_pkg::LSW_PE]   = rx_has & rx_q[uls_pkg::TAG_PE];                  // [RULE_13] [RULE_11]
    lsw[uls_pkg::LSW_FE]   = rx_has & rx_q[uls_pkg::TAG_FE];                  // [RULE_12] [RULE_11]
    lsw[uls_pkg::LSW_BI]   = rx_has & rx_q[uls_pkg::TAG_BI];                  // [RULE_09] [RULE_11]
    lsw[uls_pkg::LSW_THRE] = tx_empty;                                        // [RULE_05] [RULE_08]
    lsw[uls_pkg::LSW_TEMT] = tx_empty & ~tx_shift_busy_in;                    // [RULE_03] [RULE_04]
    lsw[uls_pkg::LSW_FERR] = fifo_en & st_reg.ferr;                           // [RULE_01]
  end

  // sticky event sources
  always_comb
  begin
    evt_set = 5'h00;
    evt_set[uls_pkg::EVT_RX]   = rx_push;
    evt_set[uls_pkg::EVT_OE]   = overrun;
    evt_set[uls_pkg::EVT_ERR]  = push_err;
    evt_set[uls_pkg::EVT_BI]   = brk_push & ~flush;
    evt_set[uls_pkg::EVT_THRE] = thre_rise;                                   // [RULE_07]
  end

  assign err_cnt_nx = flush ? 5'h00 : st_reg.err_cnt + {4'h0, push_err} - {4'h0, pop_err};

  // next state of the whole block
  always_comb
  begin
    st_next = st_reg;
    st_next.rd_data = 8'h00;
    // control and mask writes
    if (ctrl_wr)
    begin
      st_next.ctrl = wr_data_in;
    end
    if (mask_wr)
    begin
      st_next.mask = wr_data_in[4:0];
    end
    // read data for the cycle after the strobe
    if (rd_strobe_in)
    begin
      case (addr_in)
        uls_pkg::OFS_DATA: st_next.rd_data = rx_has ? rx_q[7:0] : 8'h00;
        uls_pkg::OFS_LSW:  st_next.rd_data = lsw;
        uls_pkg::OFS_CTRL: st_next.rd_data = st_reg.ctrl;
        uls_pkg::OFS_EVT:  st_next.rd_data = {3'h0, st_reg.evt};
        uls_pkg::OFS_MASK: st_next.rd_data = {3'h0, st_reg.mask};
        default:           st_next.rd_data = 8'h00;
      endcase
    end
    // event status: set wins over the clearing read
    st_next.evt = evt_set | (st_reg.evt & ~{uls_pkg::EVT_W{evt_rd}});
    // receive and transmit queue pointers and fill
    if (flush)
    begin
      st_next.rx_wp  = 4'h0;
      st_next.rx_rp  = 4'h0;
      st_next.rx_cnt = 5'h00;
      st_next.tx_wp  = 4'h0;
      st_next.tx_rp  = 4'h0;
      st_next.tx_cnt = 5'h00;
    end
    else
    begin
      st_next.rx_wp  = st_reg.rx_wp + {3'h0, rx_push};
      st_next.rx_rp  = st_reg.rx_rp + {3'h0, data_rd};
      st_next.rx_cnt = st_reg.rx_cnt + {4'h0, rx_push} - {4'h0, data_rd};     // [RULE_15]
      st_next.tx_wp  = st_reg.tx_wp + {3'h0, data_wr};                        // [RULE_06]
      st_next.tx_rp  = st_reg.tx_rp + {3'h0, tx_pop};
      st_next.tx_cnt = st_reg.tx_cnt + {4'h0, data_wr} - {4'h0, tx_pop};      // [RULE_06] [RULE_08]
    end
    // overrun: sticky until the status read, a new overrun wins
    st_next.oe = overrun | (st_reg.oe & ~lsw_rd);                             // [RULE_14]
    // error summary: set by an error entry, cleared by read or when none left
    st_next.err_cnt = err_cnt_nx;
    st_next.ferr = push_err | (st_reg.ferr & ~lsw_rd & (err_cnt_nx != 5'h00)); // [RULE_01] [RULE_02]
    // break detector
    unique case (st_reg.brk_state)
      uls_pkg::BRK_IDLE:
      begin
        if (~rx_line_in & rx_bit_tick_in)
        begin
          st_next.brk_cnt   = brk_cnt_inc;
          st_next.brk_state = brk_push ? uls_pkg::BRK_HELD : uls_pkg::BRK_COUNT;
        end
      end
      uls_pkg::BRK_COUNT:
      begin
        if (rx_line_in)
        begin
          st_next.brk_state = uls_pkg::BRK_IDLE;
        end
        else if (rx_bit_tick_in)
        begin
          st_next.brk_cnt   = brk_cnt_inc;
          st_next.brk_state = brk_push ? uls_pkg::BRK_HELD : uls_pkg::BRK_COUNT;
        end
      end
      uls_pkg::BRK_HELD:
      begin
        if (rx_line_in)
        begin
          st_next.brk_state = uls_pkg::BRK_IDLE;                              // [RULE_10]
        end
      end
      default:
      begin
        st_next.brk_state = uls_pkg::BRK_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_reg.ctrl      <= uls_pkg::CTRL_RST;
      st_reg.mask      <= uls_pkg::MASK_RST;
      st_reg.evt       <= 5'h00;
      st_reg.rd_data   <= 8'h00;
      st_reg.rx_wp     <= 4'h0;
      st_reg.rx_rp     <= 4'h0;
      st_reg.rx_cnt    <= 5'h00;
      st_reg.tx_wp     <= 4'h0;
      st_reg.tx_rp     <= 4'h0;
      st_reg.tx_cnt    <= 5'h00;
      st_reg.oe        <= 1'b0;
      st_reg.ferr      <= 1'b0;
      st_reg.err_cnt   <= 5'h00;
      st_reg.brk_state <= uls_pkg::BRK_IDLE;
      st_reg.brk_cnt   <= 4'h0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // receive queue storage, read address follows the next top
  uls_mem #(.W(uls_pkg::RX_W), .D(uls_pkg::DEPTH), .AW(uls_pkg::PTR_W)) u_rx_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (rx_push),
    .wr_addr_in  (st_reg.rx_wp),
    .wr_data_in  (rx_entry),
    .rd_addr_in  (st_next.rx_rp),
    .rd_data_out (rx_q)
  );

  // transmit queue storage
  uls_mem #(.W(uls_pkg::DATA_W), .D(uls_pkg::DEPTH), .AW(uls_pkg::PTR_W)) u_tx_mem (
    .sys_clk_in  (sys_clk_in),
    .reset_n_in  (reset_n_in),
    .wr_en_in    (data_wr),
    .wr_addr_in  (st_reg.tx_wp),
    .wr_data_in  (wr_data_in),
    .rd_addr_in  (st_next.tx_rp),
    .rd_data_out (tx_char_data_out)
  );

  // outputs
  assign rd_data_out = st_reg.rd_data;
  assign irq_out     = |(st_reg.evt & st_reg.mask);                           // [RULE_07]

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_err_in;
    fifo_en && push_err && !flush;
  endsequence

  sequence s_brk_held;
    brk_push ##1 !rx_line_in;
  endsequence

  a_err_sum_set: assert property (s_err_in |=> lsw[uls_pkg::LSW_FERR]) // [RULE_01]
    else $error("error summary not set by error entry");
  a_err_sum_clear: assert property (lsw_rd && !push_err |=> !lsw[uls_pkg::LSW_FERR]) // [RULE_02]
    else $error("error summary not cleared by status read");
  a_temt_busy: assert property (!fifo_en && data_wr |=> !lsw[uls_pkg::LSW_TEMT]) // [RULE_03]
    else $error("transmit empty while a character is held");
  a_temt_fifo: assert property (fifo_en && tx_pop && thre_rise && !tx_shift_busy_in // [RULE_04]
                                |=> lsw[uls_pkg::LSW_TEMT] || tx_shift_busy_in)
    else $error("transmit empty missing in queue mode");
  a_thre_take: assert property (!fifo_en && thre_rise |=> lsw[uls_pkg::LSW_THRE]) // [RULE_05]
    else $error("holding empty not set after shifter take");
  a_thre_write: assert property (!fifo_en && data_wr |=> !lsw[uls_pkg::LSW_THRE]) // [RULE_06]
    else $error("holding empty not cleared by write");
  a_thre_irq: assert property (thre_rise && !mask_wr // [RULE_07]
                               && st_reg.mask[uls_pkg::EVT_THRE] |=> irq_out)
    else $error("holding empty interrupt missing");
  a_fifo_write: assert property (fifo_en && data_wr ##1 !tx_pop // [RULE_08]
                                 |-> !lsw[uls_pkg::LSW_THRE])
    else $error("holding empty not cleared in queue mode");
  a_break_flag: assert property (brk_push && !rx_has && !flush // [RULE_09]
                                 |=> lsw[uls_pkg::LSW_BI])
    else $error("break flag not raised");
  a_break_once: assert property (s_brk_held |-> !brk_push) // [RULE_10]
    else $error("second break entry during one break");
  a_flags_idle: assert property (rx_push && !rx_has && !is_err(rx_entry) // [RULE_11]
                                 |=> lsw[4:2] == 3'h0)
    else $error("error flags set for a clean character");
  a_fe_top: assert property (rx_push && !rx_has && rx_entry[uls_pkg::TAG_FE] // [RULE_12]
                             |=> lsw[uls_pkg::LSW_FE])
    else $error("framing flag not on top character");
  a_pe_top: assert property (rx_push && !rx_has && rx_entry[uls_pkg::TAG_PE] // [RULE_13]
                             |=> lsw[uls_pkg::LSW_PE])
    else $error("parity flag not on top character");
  a_overrun_keep: assert property (overrun && !data_rd // [RULE_14]
                                   |=> lsw[uls_pkg::LSW_OE] && $stable(st_reg.rx_cnt))
    else $error("overrun not flagged or queue changed");
  a_ready_level: assert property (rx_push |=> lsw[uls_pkg::LSW_DR]) // [RULE_15]
    else $error("data ready missing after receive");
  a_break_zero: assert property (brk_push && !rx_has && !flush // [RULE_16]
                                 |=> rx_q == uls_pkg::BRK_ENTRY)
    else $error("break entry not all-zero with tag");

endmodule // uls_line_status

//--- verif/uls_tx_shifter_model.sv
// behavioural transmit shifter that takes characters from the status block
// assumes the block's clock and reset; hold_in lets the bench stall takes
module uls_tx_shifter_model #(
  parameter int unsigned BUSY_CYC = 12
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       reset_n_in,
  // queue side
  input  wire logic       tx_char_valid_in,
  input  wire logic [7:0] tx_char_data_in,
  input  wire logic       hold_in,
  output logic            take_out,
  output logic            busy_out,
  // bench observation
  output logic      [7:0] last_data_out,
  output logic      [7:0] take_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;

  // one-cycle take, then busy for a whole character time
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      take_out       <= 1'b0;
      busy_out       <= 1'b0;
      cnt            <= 0;
      last_data_out  <= 8'h00;
      take_count_out <= 8'h00;
    end
    else if (take_out)
    begin
      take_out       <= 1'b0;
      busy_out       <= 1'b1;
      cnt            <= BUSY_CYC;
      last_data_out  <= tx_char_data_in;
      take_count_out <= take_count_out + 8'h01;
    end
    else if (busy_out)
    begin
      cnt      <= cnt - 1;
      busy_out <= (cnt != 1);
    end
    else if (tx_char_valid_in && !hold_in)
    begin
      take_out <= 1'b1;
    end
  end
endmodule // uls_tx_shifter_model

//--- verif/uls_line_status_tb.sv
// self-checking bench of the line status block with a shifter model
// assumes the register map and reset values of the package
module uls_line_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [2:0] a; logic [7:0] d; logic [7:0] exp;} uls_row_t;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [2:0] addr    = 3'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr_stb  = 1'b0;
  logic       rd_stb  = 1'b0;
  logic [7:0] rd_data;
  logic       rx_line = 1'b1;
  logic       tick    = 1'b0;
  logic       rx_vld  = 1'b0;
  logic [7:0] rx_dat  = 8'h00;
  logic       rx_pe   = 1'b0;
  logic       rx_fe   = 1'b0;
  logic       tx_vld;
  logic [7:0] tx_dat;
  logic       take;
  logic       busy;
  logic       hold    = 1'b1;
  logic [7:0] last_dat;
  logic [7:0] take_cnt;
  logic       irq;
  int         errors = 0;
  int         total_checks = 0;
  uls_row_t   rows [8] = '{'{1'b0, 3'h1, 8'h00, 8'h60}, '{1'b0, 3'h2, 8'h00, 8'hA0},
                           '{1'b0, 3'h4, 8'h00, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'h00},
                           '{1'b0, 3'h0, 8'h00, 8'h00}, '{1'b1, 3'h5, 8'hFF, 8'h00},
                           '{1'b0, 3'h5, 8'h00, 8'h00}, '{1'b0, 3'h7, 8'h00, 8'h00}};

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  uls_line_status u_uls_line_status (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .addr_in(addr), .wr_data_in(wdata),
    .wr_strobe_in(wr_stb), .rd_strobe_in(rd_stb), .rd_data_out(rd_data),
    .rx_line_in(rx_line), .rx_bit_tick_in(tick), .rx_char_valid_in(rx_vld),
    .rx_char_data_in(rx_dat), .rx_parity_err_in(rx_pe), .rx_framing_err_in(rx_fe),
    .tx_char_valid_out(tx_vld), .tx_char_data_out(tx_dat), .tx_char_take_in(take),
    .tx_shift_busy_in(busy), .irq_out(irq));

  uls_tx_shifter_model u_uls_tx_shifter_model (
    .sys_clk_in(sys_clk), .reset_n_in(reset_n), .tx_char_valid_in(tx_vld),
    .tx_char_data_in(tx_dat), .hold_in(hold), .take_out(take), .busy_out(busy),
    .last_data_out(last_dat), .take_count_out(take_cnt));

  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 v = rd_data;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask

  // one received character, then time for the top tags to settle
  task automatic rxc(input logic [7:0] v, input logic pe, input logic fe);
    @(posedge sys_clk);
    rx_vld <= 1'b1;
    rx_dat <= v;
    rx_pe  <= pe;
    rx_fe  <= fe;
    @(posedge sys_clk);
    rx_vld <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      tick <= 1'b1;
      @(posedge sys_clk);
      tick <= 1'b0;
    end
    repeat (3) @(posedge sys_clk);
  endtask

  // hang guard
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset values and unmapped places
    for (int i = 0; i < 8; i++)
    begin
      if (rows[i].wr)
        wr(rows[i].a, rows[i].d);
      else
        rd_chk(rows[i].a, rows[i].exp);
    end
    // single-buffer receive, then overrun keeps the stored character
    rxc(8'h41, 1'b0, 1'b0);
    rd_chk(3'h1, 8'h61);
    check({7'h00, irq}, 8'h00);
    rd_chk(3'h0, 8'h41);
    rxc(8'h11, 1'b0, 1'b0);
    rxc(8'h22, 1'b0, 1'b0);
    rd_chk(3'h1, 8'h63);
    rd_chk(3'h1, 8'h61);
    rd_chk(3'h0, 8'h11);
    rd_chk(3'h3, 8'h03);
    // single-buffer transmit with the shifter stalled, then released
    wr(3'h4, 8'h10);
    wr(3'h0, 8'h55);
    rd_chk(3'h1, 8'h00);
    check({7'h00, tx_vld}, 8'h01);
    check(tx_dat, 8'h55);
    hold <= 1'b0;
    for (int i = 0; i < 20 && !busy; i++) @(posedge sys_clk);
    @(posedge sys_clk);
    #1 check({7'h00, irq}, 8'h01);
    rd_chk(3'h1, 8'h20);
    for (int i = 0; i < 40 && busy; i++) @(posedge sys_clk);
    rd_chk(3'h1, 8'h60);
    rd_chk(3'h3, 8'h10);
    repeat (2) @(posedge sys_clk);
    check({7'h00, irq}, 8'h00);
    // queue mode: error summary and top-entry tags
    wr(3'h2, 8'hA1);
    rxc(8'h33, 1'b1, 1'b0);
    rd_chk(3'h1, 8'hE5);
    rd_chk(3'h1, 8'h65);
    rd_chk(3'h0, 8'h33);
    rxc(8'h22, 1'b0, 1'b1);
    rd_chk(3'h1, 8'hE9);
    rd_chk(3'h0, 8'h22);
    // break one tick short, then a long break
    @(posedge sys_clk);
    rx_line <= 1'b0;
    ticks(9);
    rd_chk(3'h1, 8'h60);
    ticks(1);
    rd_chk(3'h1, 8'hF1);
    ticks(20);
    rd_chk(3'h1, 8'h71);
    @(posedge sys_clk);
    rx_line <= 1'b1;
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h1, 8'h60);
    // queue-mode transmit of three back-to-back bytes
    hold <= 1'b1;
    wr(3'h0, 8'hA1);
    wr(3'h0, 8'hB2);
    wr(3'h0, 8'hC3);
    rd_chk(3'h1, 8'h00);
    hold <= 1'b0;
    for (int i = 0; i < 200 && (tx_vld || busy); i++) @(posedge sys_clk);
    rd_chk(3'h1, 8'h60);
    check(take_cnt, 8'h04);
    check(last_dat, 8'hC3);
    // reset in mid-run
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd_chk(3'h1, 8'h60);
    rd_chk(3'h2, 8'hA0);
    stop_test();
  end
endmodule // uls_line_status_tb
